// File: isa_req_consts.vh
/*
  Constants for the ISA request collector and acknowledge encoder.
  Assumes inclusion by isa_request_mux_ack_encoder.v only.
*/
`ifndef ISA_REQ_CONSTS_VH
`define ISA_REQ_CONSTS_VH

// APB register byte offsets
`define REG_CONFIG        12'h000
`define REG_DMA_ROUTE     12'h004
`define REG_STATUS        12'h008
`define REG_IRQ_VIEW      12'h00C

// Config register fields
`define CFG_MUX_IRQ       0
`define CFG_ENC_DMA       1
`define CFG_KBD_EN        2
`define CFG_MOUSE_EN      3
`define CFG_EXT_RTC       4
`define CFG_SER_DIVCLK    5
`define CFG_DIV_LO        6
`define CFG_DIV_HI        7
`define CFG_RESET         32'h0000_0020

// Route register fields: pin A channel [2:0], pin B channel [10:8]
`define ROUTE_A_LO        0
`define ROUTE_B_LO        8
`define ROUTE_RESET       32'h0000_0100

// Bus clock divisor codes
`define DIV_2             2'h0
`define DIV_3             2'h1
`define DIV_4             2'h2
`define DIV_6             2'h3

// Cycles the slot select must be stable before sampling
`define SETTLE_NS         16
`define SETTLE_CYC        ((`SETTLE_NS + 7) / 8)

// Slot that carries level 15 on the DMA multiplexer
`define IRQ15_SLOT        3'h4

`endif

// File: isa_request_mux_ack_encoder.v
/*
  ISA interrupt and DMA request collector with DMA acknowledge encoder.
  Assumes one core clock clk at 125 MHz, external 8-to-1 multiplexers on
  the serial inputs, an external 3-to-8 decoder enabled by address enable,
  and internal interrupt and DMA controllers reached through plain ports.
*/
// What this block does
// - Mux mode reads eight interrupt levels serially at divide by 4 or 6
// - Select is high pin, bus clock, low pin
// - DMA mux slots 0-7 carry DRQ0-3,IRQ15,DRQ5-7
// - Mux mode chosen by configuration, else dedicated pins
// - Discrete request pins route to any channel
// - Same channel on both pins ORs them
// - Each ack pin follows its paired request channel
// - Encoded mode drives channel as three-bit code
// - Terminal count output follows active channel count
// - Level 10 pin used only with divided serial clock
// - Levels 1, 12 from keyboard when enabled
// - Level 8 pin used only with external clock
// - Interrupt pins treated as asynchronous
// - Level 3,4,5 pins become selects and serial input
// - Encoded mode repurposes request and ack pins
// - CPU interrupt high while controller request pending
// - FPU error raises interrupt level 13
// - Write to F0/F1 during error asserts ignore
// - Bus clock is core divided by 2,3,4,6
// - Address enable asserted in DMA and refresh
`timescale 1ns/1ps
`include "isa_req_consts.vh"

module isa_request_mux_ack_encoder (
  input  wire        clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Shared interrupt pins: level 3,4 double as selects, 5 as serial input
  input  wire        irq3_in,
  output reg         irq3_out,
  output reg         irq3_oe_n,
  input  wire        irq4_in,
  output reg         irq4_out,
  output reg         irq4_oe_n,
  input  wire        irq5_in,
  input  wire        irq6_in,
  input  wire        irq7_in,
  input  wire        irq9_in,
  input  wire        irq11_in,
  input  wire        irq14_in,
  input  wire        irq10_in,
  input  wire        irq1_in,
  input  wire        irq12_in,
  input  wire        rtc_int_in_n,
  // Internal keyboard controller sources
  input  wire        kbd_irq,
  input  wire        mouse_irq,
  // DMA pins; in encoded mode pin B and ack pins carry the code
  input  wire        dma_request_pin_a,
  input  wire        dma_request_pin_b,
  output reg         dma_request_pin_b_out,
  output reg         dma_request_pin_b_oe_n,
  output reg         dma_ack_pin_a_n,
  output reg         dma_ack_pin_b_n,
  // Internal DMA controller side
  input  wire        dmac_ack_valid,
  input  wire [2:0]  dmac_ack_channel,
  input  wire        dmac_tc,
  input  wire        dmac_cycle,
  input  wire        refresh_cycle,
  output reg  [7:0]  dmac_req,
  output reg         terminal_count,
  output reg         addr_enable,
  // Internal interrupt controller side
  output reg  [15:0] pic_irq,
  input  wire        pic_pending,
  output reg         cpu_int_request,
  // Floating-point error handling
  input  wire        fpu_error_in_n,
  input  wire        io_write,
  input  wire [15:0] io_addr,
  output reg         fpu_error_ignore_n,
  // ISA bus clock, also middle select bit
  output reg         bus_clock
);

  // Two-stage synchronisers; first stage read only by second
  reg [13:0] sync_a;
  reg [13:0] sync_b;
  wire [13:0] raw_in = {fpu_error_in_n, rtc_int_in_n, irq12_in, irq1_in,
                        irq10_in, irq14_in, irq11_in, irq9_in, irq7_in,
                        irq6_in, irq5_in, irq4_in, irq3_in, dma_request_pin_b};
  reg  dma_a_s1;
  reg  dma_a_s2;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a   <= 14'h3000;
      sync_b   <= 14'h3000;
      dma_a_s1 <= 1'b0;
      dma_a_s2 <= 1'b0;
    end else begin
      sync_a   <= raw_in;
      sync_b   <= sync_a;
      dma_a_s1 <= dma_request_pin_a;
      dma_a_s2 <= dma_a_s1;
    end
  end

  wire s_drq_b  = sync_b[0];
  wire s_irq3   = sync_b[1];
  wire s_irq4   = sync_b[2];
  wire s_irq5   = sync_b[3];
  wire s_irq6   = sync_b[4];
  wire s_irq7   = sync_b[5];
  wire s_irq9   = sync_b[6];
  wire s_irq11  = sync_b[7];
  wire s_irq14  = sync_b[8];
  wire s_irq10  = sync_b[9];
  wire s_irq1   = sync_b[10];
  wire s_irq12  = sync_b[11];
  wire s_rtc_n  = sync_b[12];
  wire s_fpu_error_in_n_n = sync_b[13];

  // Configuration registers
  reg [31:0] config_reg;
  reg [31:0] route_reg;
  wire       mux_irq  = config_reg[`CFG_MUX_IRQ];
  wire       enc_dma  = config_reg[`CFG_ENC_DMA];
  wire [1:0] div_sel  = config_reg[`CFG_DIV_HI:`CFG_DIV_LO];
  wire [2:0] chan_a   = route_reg[`ROUTE_A_LO+2:`ROUTE_A_LO];
  wire [2:0] chan_b   = route_reg[`ROUTE_B_LO+2:`ROUTE_B_LO];

  // One-hot decode of a channel number
  function [7:0] one_hot;
    input [2:0] ch;
    begin
      one_hot = 8'h01 << ch;
    end
  endfunction

  // Bus clock divider: high for one third at divide by 3, half otherwise
  reg  [2:0] div_cnt;
  reg  [2:0] div_last;
  reg  [2:0] div_high;
  always @* begin
    case (div_sel)
      `DIV_2: begin div_last = 3'h1; div_high = 3'h1; end
      `DIV_3: begin div_last = 3'h2; div_high = 3'h2; end // One of three high
      `DIV_4: begin div_last = 3'h3; div_high = 3'h2; end
      default: begin div_last = 3'h5; div_high = 3'h3; end
    endcase
  end

  // Slot sequencer; select advances once per bus clock period.
  // The slot pins take the next slot at the same edge as the bus
  // clock falls, so each of the eight codes stands for one half of
  // a bus clock period, or one or two thirds at divide by 3. The middle bit is the bus clock itself.
  reg  [2:0] slot;
  wire       period_end = (div_cnt >= div_last);
  wire [2:0] next_slot  = period_end ? slot + 3'h1 : slot;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt   <= 3'h0;
      bus_clock <= 1'b0;
      slot      <= 3'h0;
    end else begin
      div_cnt   <= period_end ? 3'h0 : div_cnt + 3'h1;
      bus_clock <= period_end ? 1'b0 : ((div_cnt + 3'h1) >= div_high);
      slot      <= next_slot;
    end
  end

  // Select pins: high on level 3 pin, low on level 4 pin.
  // Driven from the next slot so they switch with the bus clock edge.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq3_out  <= 1'b0;
      irq3_oe_n <= 1'b1;
      irq4_out  <= 1'b0;
      irq4_oe_n <= 1'b1;
    end else begin
      irq3_out  <= next_slot[2];
      irq4_out  <= next_slot[0];
      irq3_oe_n <= ~mux_irq;
      irq4_oe_n <= ~mux_irq;
    end
  end

  // Settle tracking of the code on the select pins.
  // A code that changed at the last edge has stood zero whole cycles;
  // the multiplexer output is trusted once the code has stood for the
  // settle time at the sampling edge. At divide by 2 and in the high
  // third of divide by 3 no code stands that long, so all eight serial
  // inputs are collected only at divide by 4 or 6; divide by 3 collects the four codes with the bus clock low.
  wire [2:0] pin_code = {irq3_out, bus_clock, irq4_out};
  reg  [2:0] code_prev;
  reg  [1:0] settle;
  wire       fresh    = (pin_code != code_prev);
  wire [1:0] stood    = fresh ? 2'h0 : settle;
  wire       settled  = (stood >= `SETTLE_CYC - 1);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      code_prev <= 3'h0;
      settle    <= 2'h0;
    end else begin
      code_prev <= pin_code;
      if (fresh) begin
        settle <= 2'h1;
      end else if (settle != 2'h3) begin
        settle <= settle + 2'h1;
      end
    end
  end

  // Sample tags travel two stages beside the serial data, so that the
  // code paired with each synchronised bit is the one that stood on
  // the pins when the bit entered the first synchroniser stage.
  reg        take_a;
  reg        take_b;
  reg  [2:0] code_a;
  reg  [2:0] code_b;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      take_a <= 1'b0;
      take_b <= 1'b0;
      code_a <= 3'h0;
      code_b <= 3'h0;
    end else begin
      take_a <= settled;
      code_a <= pin_code;
      take_b <= take_a;
      code_b <= code_a;
    end
  end

  // Serial slot capture, one bit per settled code
  reg  [7:0] mux_irqs;
  reg  [7:0] mux_drqs;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mux_irqs <= 8'h00;
      mux_drqs <= 8'h00;
    end else if (take_b) begin
      mux_irqs[code_b] <= s_irq5;
      mux_drqs[code_b] <= dma_a_s2;
    end
  end

  // Interrupt level assembly
  reg [15:0] next_pic;
  always @* begin
    next_pic       = 16'h0000;
    next_pic[1]    = config_reg[`CFG_KBD_EN] ? kbd_irq : s_irq1;
    next_pic[12]   = config_reg[`CFG_KBD_EN] ?
                     (config_reg[`CFG_MOUSE_EN] & mouse_irq) : s_irq12;
    next_pic[8]    = config_reg[`CFG_EXT_RTC] & ~s_rtc_n;
    next_pic[10]   = config_reg[`CFG_SER_DIVCLK] & s_irq10;
    next_pic[13]   = ~s_fpu_error_in_n_n;
    if (mux_irq) begin
      next_pic[3]  = mux_irqs[0];
      next_pic[4]  = mux_irqs[1];
      next_pic[5]  = mux_irqs[2];
      next_pic[6]  = mux_irqs[3];
      next_pic[7]  = mux_irqs[4];
      next_pic[9]  = mux_irqs[5];
      next_pic[11] = mux_irqs[6];
      next_pic[14] = mux_irqs[7];
    end else begin
      next_pic[3]  = s_irq3;
      next_pic[4]  = s_irq4;
      next_pic[5]  = s_irq5;
      next_pic[6]  = s_irq6;
      next_pic[7]  = s_irq7;
      next_pic[9]  = s_irq9;
      next_pic[11] = s_irq11;
      next_pic[14] = s_irq14;
    end
    next_pic[15]   = enc_dma & mux_drqs[`IRQ15_SLOT];
  end

  // DMA request assembly
  reg [7:0] next_drq;
  always @* begin
    if (enc_dma) begin
      next_drq = mux_drqs & ~one_hot(`IRQ15_SLOT);
    end else begin
      next_drq = (dma_a_s2 ? one_hot(chan_a) : 8'h00) |
                 (s_drq_b  ? one_hot(chan_b) : 8'h00);
    end
  end

  // Request outputs, acknowledges, terminal count, CPU interrupt
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pic_irq                <= 16'h0000;
      dmac_req               <= 8'h00;
      dma_ack_pin_a_n        <= 1'b1;
      dma_ack_pin_b_n        <= 1'b1;
      dma_request_pin_b_out  <= 1'b0;
      dma_request_pin_b_oe_n <= 1'b1;
      terminal_count         <= 1'b0;
      addr_enable            <= 1'b0;
      cpu_int_request        <= 1'b0;
    end else begin
      pic_irq  <= next_pic;
      dmac_req <= next_drq;
      dma_request_pin_b_oe_n <= ~enc_dma;
      if (enc_dma) begin
        dma_request_pin_b_out <= dmac_ack_channel[2];
        dma_ack_pin_a_n       <= dmac_ack_channel[1];
        dma_ack_pin_b_n       <= dmac_ack_channel[0];
      end else begin
        dma_request_pin_b_out <= 1'b0;
        dma_ack_pin_a_n <= ~(dmac_ack_valid && dmac_ack_channel == chan_a);
        dma_ack_pin_b_n <= ~(dmac_ack_valid && dmac_ack_channel == chan_b);
      end
      terminal_count  <= dmac_tc & dmac_ack_valid;
      addr_enable     <= dmac_cycle | refresh_cycle;
      cpu_int_request <= pic_pending;
    end
  end

  // Error ignore: set on write to F0/F1 during error, held until error ends
  wire ign_hit = io_write && ~s_fpu_error_in_n_n && (io_addr[15:1] == 15'h0078);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fpu_error_ignore_n <= 1'b1;
    end else if (s_fpu_error_in_n_n) begin
      fpu_error_ignore_n <= 1'b1;
    end else if (ign_hit) begin
      fpu_error_ignore_n <= 1'b0;
    end
  end

  // APB slave, zero wait state
  wire apb_setup = psel && !penable;
  wire apb_wr    = psel && penable && pwrite;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      config_reg <= `CFG_RESET;
      route_reg  <= `ROUTE_RESET;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      if (apb_setup) begin
        case (paddr)
          `REG_CONFIG:   prdata <= {24'h00_0000, config_reg[7:0]};
          `REG_DMA_ROUTE: prdata <= {21'h00_0000, route_reg[10:8], 5'h00,
                                     route_reg[2:0]};
          `REG_STATUS:   prdata <= {16'h0000, dmac_req, 5'h00, slot};
          `REG_IRQ_VIEW: prdata <= {16'h0000, pic_irq};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (apb_wr && pready) begin
        case (paddr)
          `REG_CONFIG:    config_reg <= {24'h00_0000, pwdata[7:0]};
          `REG_DMA_ROUTE: route_reg  <= {21'h00_0000, pwdata[10:8], 5'h00,
                                         pwdata[2:0]};
          default:        config_reg <= config_reg;
        endcase
      end
    end
  end

endmodule // isa_request_mux_ack_encoder

// File: isa_far_side.sv
/* Far-side model: the two external 8-to-1 multiplexers on the serial pins.
   Assumes select bits from the two select pins and the bus clock. */
`timescale 1ns/1ps
module isa_far_side (
  input  logic       sel_hi,
  input  logic       sel_mid,
  input  logic       sel_lo,
  input  logic [7:0] irq_lv,
  input  logic [7:0] drq_lv,
  output logic       mux_irq,
  output logic       mux_drq
);
  // Input n carries list entry n, after a short settling delay
  assign #3 mux_irq = irq_lv[{sel_hi, sel_mid, sel_lo}];
  assign #3 mux_drq = drq_lv[{sel_hi, sel_mid, sel_lo}];
endmodule // isa_far_side

// File: isa_req_chk_sva.sv
/* Port checker for the request collector.
   Assumes one core clock and an active-high async reset. */
`timescale 1ns/1ps
module isa_req_chk (
  input logic        clk,
  input logic        rst,
  input logic        psel,
  input logic        penable,
  input logic        pready,
  input logic        pic_pending,
  input logic        cpu_int_request,
  input logic        fpu_error_in_n,
  input logic        fpu_error_ignore_n,
  input logic [15:0] pic_irq,
  input logic        dmac_tc,
  input logic        dmac_ack_valid,
  input logic [2:0]  dmac_ack_channel,
  input logic        terminal_count,
  input logic        dma_request_pin_b_oe_n,
  input logic        dma_request_pin_b_out,
  input logic        dma_ack_pin_a_n,
  input logic        dma_ack_pin_b_n,
  input logic        addr_enable,
  input logic        dmac_cycle,
  input logic        refresh_cycle
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Acknowledge code as seen on the three shared pins
  wire [2:0] code = {dma_request_pin_b_out, dma_ack_pin_a_n, dma_ack_pin_b_n};
  // Encoded mode with one channel acknowledged steadily
  sequence ack_held;
    (!dma_request_pin_b_oe_n && dmac_ack_valid && $stable(dmac_ack_channel)) [*3];
  endsequence
  // Output relations
  AST_INT: assert property (cpu_int_request == $past(pic_pending))
    else $error("cpu interrupt off pending");
  AST_IRQ13: assert property (!fpu_error_in_n [*4] |=> pic_irq[13])
    else $error("level 13 missing");
  AST_IGN: assert property (fpu_error_in_n [*4] |=> fpu_error_ignore_n)
    else $error("ignore without error");
  AST_ENC: assert property (ack_held |-> code == dmac_ack_channel)
    else $error("bad ack code");
  AST_TC: assert property ((dmac_tc && dmac_ack_valid) [*4] |-> terminal_count)
    else $error("count end missing");
  AST_TC_OFF: assert property (!dmac_tc [*4] |-> !terminal_count)
    else $error("count end spurious");
  AST_AEN: assert property (addr_enable == $past(dmac_cycle || refresh_cycle))
    else $error("address enable off cycle type");
  AST_RDY: assert property (psel && !penable |=> pready)
    else $error("no ready");
  AST_RDY_PH: assert property (pready |-> psel && penable)
    else $error("ready off phase");
endmodule // isa_req_chk

bind isa_request_mux_ack_encoder isa_req_chk chk_u (.*);

// File: isa_request_mux_ack_encoder_tb.sv
/* Self-checking bench for the request collector.
   Assumes the checker bind and the far-side multiplexer model. */
`timescale 1ns/1ps
module isa_request_mux_ack_encoder_tb;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err, t;
  logic        kbd_irq = 0, mouse_irq = 0, rtc_int_in_n = 1, dra = 0, drb = 0;
  logic        dmac_ack_valid = 0, dmac_tc = 0, pic_pending = 0;
  logic        fpu_error_in_n = 1, io_write = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, cfg = 32'h0000_0020, rd;
  logic [15:0] iv = 0, io_addr = 0;
  logic [7:0]  lv = 0, dv = 0;
  logic [2:0]  ra, rb, dmac_ack_channel = 0;
  logic [31:0] cfgs [4] = '{32'h0000_0020, 32'h0000_0000, 32'h0000_002c, 32'h0000_0030};
  int          pers [4] = '{2, 3, 4, 6};
  int          failures = 0, cmp_count = 0, n;
  wire [31:0]  prdata;
  wire [15:0]  pic_irq;
  wire [7:0]   dmac_req;
  wire         pready, pslverr, irq3_out, irq3_oe_n, irq4_out, irq4_oe_n, mux_irq, mux_drq;
  wire         dma_request_pin_b_out, dma_request_pin_b_oe_n, dma_ack_pin_a_n, dma_ack_pin_b_n;
  wire         terminal_count, addr_enable, cpu_int_request, fpu_error_ignore_n, bus_clock;
  logic        dmac_cycle = 0, refresh_cycle = 0;
  // Board decoder: enabled by address enable, output n for code n
  wire [7:0]   ext_dack_n = addr_enable ? ~(8'h01 << {dma_request_pin_b_out,
                 dma_ack_pin_a_n, dma_ack_pin_b_n}) : 8'hff;
  // Pin levels, shared pins resolved from their enables
  wire irq3_in = irq3_oe_n ? iv[3] : irq3_out;
  wire irq4_in = irq4_oe_n ? iv[4] : irq4_out;
  wire irq5_in = cfg[0] ? mux_irq : iv[5];
  wire irq6_in = iv[6], irq7_in = iv[7], irq9_in = iv[9], irq10_in = iv[10];
  wire irq11_in = iv[11], irq14_in = iv[14], irq1_in = iv[1], irq12_in = iv[12];
  wire dma_request_pin_a = cfg[1] ? mux_drq : dra;
  wire dma_request_pin_b = dma_request_pin_b_oe_n ? drb : dma_request_pin_b_out;

  isa_request_mux_ack_encoder dut_u (.*);
  isa_far_side far_u (.sel_hi(irq3_out), .sel_mid(bus_clock), .sel_lo(irq4_out),
    .irq_lv(lv), .drq_lv(dv), .mux_irq(mux_irq), .mux_drq(mux_drq));

  always #4 clk = ~clk;

  // Random pending flag from the interrupt controller
  always @(posedge clk)
    if (!rst)
      pic_pending <= 1'($urandom);

  // Watchdog far above the few hundred cycles the tests need
  initial begin
    #100us;
    failures++;
    test_done();
  end

  task automatic test_done;
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask

  // One APB transfer; data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Expected controller inputs for the present pins and setup
  function automatic logic [15:0] pic_exp();
    logic [15:0] e;
    e = iv & 16'h5efa;
    if (cfg[0]) begin
      e = e & 16'h1402;
      {e[14], e[11], e[9], e[7], e[6], e[5], e[4], e[3]} = lv;
    end
    e[15] = cfg[1] & dv[4];
    e[10] = e[10] & cfg[5];
    if (cfg[2]) begin
      e[1] = kbd_irq;
      e[12] = mouse_irq & cfg[3];
    end
    e[8] = cfg[4] & !rtc_int_in_n;
    e[13] = !fpu_error_in_n;
    return e;
  endfunction

  initial begin
    t = 1'($urandom(32'h4357_8c7d));
    repeat (20) @(posedge clk);
    rst <= 0;
    // Reset values and an unmapped offset
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000_0020);
    apb(0, 12'h004, 0);
    chk(rd, 32'h0000_0100);
    apb(1, 12'h010, 32'h0000_00ff);
    chk(err, 1);
    // Dedicated pins under each source setup
    for (int i = 0; i < 8; i++) begin
      cfg <= cfgs[i % 4];
      iv <= 16'($urandom);
      {kbd_irq, mouse_irq, rtc_int_in_n} <= 3'($urandom);
      apb(1, 12'h000, cfgs[i % 4]);
      wt(6);
      chk(pic_irq, pic_exp());
    end
    // Discrete routing, shared channel, paired acknowledges
    for (int c = 0; c < 8; c++) begin
      ra = 3'(c);
      rb = (c == 7) ? 3'(c) : 3'($urandom);
      apb(1, 12'h004, {21'h0, rb, 5'h0, ra});
      {dra, drb, dmac_ack_valid} <= 3'b111;
      dmac_ack_channel <= ra;
      wt(5);
      chk(dmac_req, (8'h01 << ra) | (8'h01 << rb));
      chk({dma_ack_pin_a_n, dma_ack_pin_b_n}, {1'b0, rb != ra});
    end
    {dra, drb} <= 2'b00;
    // Error ignore on ports F0 and F1 only
    for (int i = 0; i < 3; i++) begin
      fpu_error_in_n <= 0;
      wt(6);
      chk(pic_irq[13], 1);
      io_addr <= 16'h00f0 + 16'(i);
      io_write <= 1;
      wt(1);
      io_write <= 0;
      wt(5);
      chk(fpu_error_ignore_n, i == 2);
      fpu_error_in_n <= 1;
      wt(6);
      chk(fpu_error_ignore_n, 1);
    end
    // Serial slots through the multiplexers
    // Divide by 4 so that every select code stands long enough to settle
    cfg <= 32'h0000_00a3;
    apb(1, 12'h000, 32'h0000_00a3);
    repeat (2) begin
      lv <= 8'($urandom);
      dv <= 8'($urandom);
      wt(150);
      chk(pic_irq, pic_exp());
      chk(dmac_req, dv & 8'hef);
    end
    // Acknowledge code and count end per channel
    for (int c = 0; c < 8; c++) begin
      t = 1'($urandom);
      dmac_tc <= t;
      dmac_ack_channel <= 3'(c);
      wt(5);
      chk({dma_request_pin_b_out, dma_ack_pin_a_n, dma_ack_pin_b_n}, c);
      chk(terminal_count, t);
    end
    // Address enable in DMA and refresh cycles, gating the decoder
    dmac_cycle <= 1;
    wt(5);
    chk(addr_enable, 1);
    chk(ext_dack_n, 8'h7f);
    dmac_cycle <= 0;
    refresh_cycle <= 1;
    wt(3);
    chk(addr_enable, 1);
    refresh_cycle <= 0;
    wt(3);
    chk(addr_enable, 0);
    // Bus clock rises in 24 cycles for each divisor
    for (int d = 0; d < 4; d++) begin
      cfg <= 32'h0000_0020 | 32'(d << 6);
      apb(1, 12'h000, 32'h0000_0020 | 32'(d << 6));
      wt(8);
      n = 0;
      repeat (24) begin
        t = bus_clock;
        @(posedge clk);
        n += int'(!t && bus_clock);
      end
      chk(n, 24 / pers[d]);
    end
    test_done();
  end
endmodule // isa_request_mux_ack_encoder_tb
